// ===== hw/i2cmtw_top.sv
// i2cmtw top: master-transmit wait and flag control on the system clock
`timescale 1ns/1ps
`include "i2cmtw_cfg.svh"

module i2cmtw_top (
    input  wire logic       sys_clk_in,
    input  wire logic       link_clk_in,
    input  wire logic       rst_in,
    input  wire logic       dma_mode_in,
    input  wire logic       fifo_mode_in,
    input  wire logic       wait_point_select_in,
    input  wire logic       reserved_detect_in,
    input  wire logic       tx_write_in,
    input  wire logic [7:0] tx_data_in,
    input  wire logic       master_select_write_in,
    input  wire logic       master_select_data_in,
    input  wire logic       repeat_start_request_in,
    input  wire logic       event_flag_clear_in,
    input  wire logic       sda_in,
    output logic            bus_event_flag_out,
    output logic            tx_bus_idle_flag_out,
    output logic            tx_data_empty_out,
    output logic            master_select_out,
    output logic            bus_busy_status_out,
    output logic            nack_out,
    output logic            arb_lost_out,
    output logic [7:0]      receive_data_out,
    output logic            scl_out,
    output logic            scl_oe_out,
    output logic            sda_out,
    output logic            sda_oe_out
);

    i2cmtw_pkg::i2cmtw_sys_type q_q;
    i2cmtw_pkg::i2cmtw_sys_type q_d;
    i2cmtw_pkg::i2cmtw_rpt_type rpt;
    logic                       rpt_tgl;
    logic                       seen;

    // open-drain lines: only ever pulled low
    assign scl_out              = 1'b0;
    assign sda_out              = 1'b0;
    assign bus_event_flag_out   = q_q.evt;
    assign tx_bus_idle_flag_out = q_q.tx_bus_idle_flag;
    assign tx_data_empty_out    = q_q.tde;
    assign master_select_out    = q_q.ms;
    assign bus_busy_status_out  = q_q.busy;
    assign nack_out             = q_q.nack;
    assign arb_lost_out         = q_q.arb;
    assign receive_data_out     = q_q.receive_data_reg;
    assign seen                 = q_q.rs2 != q_q.rs3;

    // hand one command to the link; data stays put until the next toggle
    function automatic i2cmtw_pkg::i2cmtw_sys_type issue(
        input i2cmtw_pkg::i2cmtw_sys_type s,
        input i2cmtw_pkg::i2cmtw_op_type  op,
        input logic [7:0]                 data
    );
        i2cmtw_pkg::i2cmtw_sys_type r;
        r         = s;
        r.cmd     = '{op, data};
        r.cmd_tgl = ~s.cmd_tgl;
        r.wait_on = 1'b0;
        r.tx_bus_idle_flag     = 1'b0;
        return r;
    endfunction : issue

    // enter the wait; the flag raised depends on who must release it
    function automatic i2cmtw_pkg::i2cmtw_sys_type hold(
        input i2cmtw_pkg::i2cmtw_sys_type s,
        input logic                       by_idle,
        input logic                       at_b
    );
        i2cmtw_pkg::i2cmtw_sys_type r;
        r         = s;
        r.wait_on = 1'b1;
        r.wait_b  = at_b;
        if (by_idle) begin
            r.tx_bus_idle_flag = 1'b1;
        end else begin
            r.evt = 1'b1;
        end
        return r;
    endfunction : hold

    // after an ack: send the held byte, or stop, or wait for software
    function automatic i2cmtw_pkg::i2cmtw_sys_type next_byte(
        input i2cmtw_pkg::i2cmtw_sys_type s,
        input logic                       dma
    );
        i2cmtw_pkg::i2cmtw_sys_type r;
        if (!s.ms) begin
            r = issue(s, i2cmtw_pkg::op_stop, s.transmit_data_reg);
        end else if (s.tde) begin
            r = hold(s, dma, 1'b1);
        end else begin
            r     = issue(s, i2cmtw_pkg::op_send, s.transmit_data_reg);
            r.tde = 1'b1;
        end
        return r;
    endfunction : next_byte

    always_comb begin
        q_d     = q_q;
        q_d.rs1 = rpt_tgl;
        q_d.rs2 = q_q.rs1;
        q_d.rs3 = q_q.rs2;

        if (tx_write_in) begin
            q_d.transmit_data_reg = tx_data_in;
            q_d.tde = 1'b0;
        end
        if (event_flag_clear_in) begin
            q_d.evt = 1'b0;
        end

        if (master_select_write_in && master_select_data_in && !q_q.busy) begin
            // the address byte leaves from the transmit holding register
            q_d      = issue(q_d, i2cmtw_pkg::op_start, q_d.transmit_data_reg);
            q_d.ms   = 1'b1;
            q_d.busy = 1'b1;
            q_d.addr = 1'b1;
            q_d.arb  = 1'b0;
            q_d.nack = 1'b0;
            q_d.receive_data_reg  = q_d.transmit_data_reg;
            q_d.tde  = 1'b1;
        end else if (master_select_write_in && !master_select_data_in) begin
            q_d.ms = 1'b0;
            if (q_q.wait_on) begin
                q_d     = issue(q_d, i2cmtw_pkg::op_stop, q_q.transmit_data_reg);
                q_d.evt = 1'b0;
            end
        end else if (repeat_start_request_in && q_q.wait_on && q_q.ms) begin
            q_d      = issue(q_d, i2cmtw_pkg::op_start, q_d.transmit_data_reg);
            q_d.evt  = 1'b0;
            q_d.addr = 1'b1;
            q_d.receive_data_reg  = q_d.transmit_data_reg;
            q_d.tde  = 1'b1;
        end else if (q_q.wait_on && q_q.evt && event_flag_clear_in) begin
            if (!q_q.ms) begin
                q_d = issue(q_d, i2cmtw_pkg::op_stop, q_q.transmit_data_reg);
            end else if (!q_q.wait_b) begin
                q_d = issue(q_d, i2cmtw_pkg::op_cont, q_q.transmit_data_reg);
            end else begin
                q_d     = issue(q_d, i2cmtw_pkg::op_send, q_d.transmit_data_reg);
                q_d.tde = 1'b1;
            end
        end else if (q_q.wait_on && q_q.tx_bus_idle_flag && tx_write_in) begin
            // a dma write both supplies the byte and lets the bus go
            if (!q_q.wait_b) begin
                q_d = issue(q_d, i2cmtw_pkg::op_cont, tx_data_in);
            end else begin
                q_d     = issue(q_d, i2cmtw_pkg::op_send, tx_data_in);
                q_d.tde = 1'b1;
            end
        end

        // link reports come last so a hardware set beats a software clear
        if (seen) begin
            case (rpt.kind)
                i2cmtw_pkg::rpt_bits: begin
                    if (!q_d.ms) begin
                        q_d = issue(q_d, i2cmtw_pkg::op_stop, q_d.transmit_data_reg);
                    end else if (q_q.addr) begin
                        if (reserved_detect_in) begin
                            q_d = hold(q_d, 1'b0, 1'b0);
                        end else begin
                            q_d = issue(q_d, i2cmtw_pkg::op_cont, q_d.transmit_data_reg);
                        end
                    end else if (wait_point_select_in && q_d.tde) begin
                        q_d = hold(q_d, dma_mode_in, 1'b0);
                    end else begin
                        q_d = issue(q_d, i2cmtw_pkg::op_cont, q_d.transmit_data_reg);
                    end
                end
                i2cmtw_pkg::rpt_ack: begin
                    q_d.nack = ~rpt.ack;
                    q_d.addr = 1'b0;
                    if (!rpt.ack && q_d.ms) begin
                        // nack always waits on the event flag, dma or not
                        q_d = hold(q_d, 1'b0, 1'b1);
                    end else if (!q_d.ms || !rpt.ack) begin
                        q_d = issue(q_d, i2cmtw_pkg::op_stop, q_d.transmit_data_reg);
                    end else if (q_q.addr && !reserved_detect_in && !fifo_mode_in) begin
                        q_d = hold(q_d, dma_mode_in, 1'b1);
                    end else begin
                        q_d = next_byte(q_d, dma_mode_in);
                    end
                end
                i2cmtw_pkg::rpt_arb: begin
                    q_d.arb     = 1'b1;
                    q_d.ms      = 1'b0;
                    q_d.busy    = 1'b0;
                    q_d.wait_on = 1'b0;
                    if (!dma_mode_in) begin
                        q_d.evt = 1'b1;
                    end
                end
                i2cmtw_pkg::rpt_done: begin
                    q_d.busy = 1'b0;
                    q_d.ms   = 1'b0;
                end
                default: q_d.busy = q_q.busy;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            q_q      <= '0;
            q_q.tde  <= `I2CMTW_TDE_RST;
            q_q.evt  <= `I2CMTW_FLAG_RST;
            q_q.tx_bus_idle_flag  <= `I2CMTW_FLAG_RST;
            q_q.transmit_data_reg  <= `I2CMTW_BYTE_RST;
            q_q.receive_data_reg  <= `I2CMTW_BYTE_RST;
        end else begin
            q_q <= q_d;
        end
    end

    // bit engine in the link clock domain; commands and reports cross by toggle
    i2cmtw_link u_link (
        .link_clk_in (link_clk_in),
        .rst_in      (rst_in),
        .sda_in      (sda_in),
        .cmd_tgl_in  (q_q.cmd_tgl),
        .cmd_in      (q_q.cmd),
        .rpt_tgl_out (rpt_tgl),
        .rpt_out     (rpt),
        .scl_oe_out  (scl_oe_out),
        .sda_oe_out  (sda_oe_out)
    );

endmodule : i2cmtw_top

// ===== hw/i2cmtw_cfg.svh
// i2cmtw constants: link phases, bit counts and reset values
`ifndef I2CMTW_CFG_SVH
`define I2CMTW_CFG_SVH

// quarter phases of one scl bit period on the link clock
`define I2CMTW_PH_DRIVE 2'h0
`define I2CMTW_PH_RISE  2'h1
`define I2CMTW_PH_MID   2'h2
`define I2CMTW_PH_FALL  2'h3

// index of the last bit of a byte
`define I2CMTW_BIT_LAST 3'h7

// reset values of the software-visible state
`define I2CMTW_TDE_RST  1'b1
`define I2CMTW_FLAG_RST 1'b0
`define I2CMTW_BYTE_RST 8'h00

`endif

// ===== hw/i2cmtw_pkg.sv
// i2cmtw types: link commands, link reports and the state of both modules
package i2cmtw_pkg;

    typedef enum logic [1:0] {
        op_start,
        op_cont,
        op_send,
        op_stop
    } i2cmtw_op_type;

    typedef enum logic [1:0] {
        rpt_bits,
        rpt_ack,
        rpt_arb,
        rpt_done
    } i2cmtw_kind_type;

    typedef enum logic [2:0] {
        st_idle,
        st_start,
        st_bits,
        st_hold_a,
        st_ack,
        st_hold_b,
        st_stop
    } i2cmtw_link_st_type;

    typedef struct packed {
        i2cmtw_op_type op;
        logic [7:0]    data;
    } i2cmtw_cmd_type;

    typedef struct packed {
        i2cmtw_kind_type kind;
        logic            ack;
    } i2cmtw_rpt_type;

    typedef struct packed {
        i2cmtw_link_st_type st;
        logic [1:0]         ph;
        logic [2:0]         bitn;
        logic [7:0]         sh;
        logic               scl_oe;
        logic               sda_oe;
        logic               c1;
        logic               c2;
        logic               c3;
        logic               d1;
        logic               d2;
        logic               rtgl;
        i2cmtw_rpt_type     rpt;
    } i2cmtw_link_type;

    typedef struct packed {
        logic           ms;
        logic           tde;
        logic [7:0]     transmit_data_reg;
        logic [7:0]     receive_data_reg;
        logic           evt;
        logic           tx_bus_idle_flag;
        logic           busy;
        logic           addr;
        logic           wait_on;
        logic           wait_b;
        logic           nack;
        logic           arb;
        i2cmtw_cmd_type cmd;
        logic           cmd_tgl;
        logic           rs1;
        logic           rs2;
        logic           rs3;
    } i2cmtw_sys_type;

endpackage : i2cmtw_pkg

// ===== hw/i2cmtw_link.sv
// i2cmtw link engine: scl and sda sequencing on the link clock
`timescale 1ns/1ps
`include "i2cmtw_cfg.svh"

module i2cmtw_link (
    input  wire logic                   link_clk_in,
    input  wire logic                   rst_in,
    input  wire logic                   sda_in,
    input  wire logic                   cmd_tgl_in,
    input  wire i2cmtw_pkg::i2cmtw_cmd_type cmd_in,
    output logic                        rpt_tgl_out,
    output i2cmtw_pkg::i2cmtw_rpt_type  rpt_out,
    output logic                        scl_oe_out,
    output logic                        sda_oe_out
);

    i2cmtw_pkg::i2cmtw_link_type q_q;
    i2cmtw_pkg::i2cmtw_link_type q_d;

    logic go;

    assign go          = q_q.c2 != q_q.c3;
    assign rpt_tgl_out = q_q.rtgl;
    assign rpt_out     = q_q.rpt;
    assign scl_oe_out  = q_q.scl_oe;
    assign sda_oe_out  = q_q.sda_oe;

    always_comb begin
        q_d    = q_q;
        q_d.c1 = cmd_tgl_in;
        q_d.c2 = q_q.c1;
        q_d.c3 = q_q.c2;
        q_d.d1 = sda_in;
        q_d.d2 = q_q.d1;
        q_d.ph = q_q.ph + 2'h1;
        case (q_q.st)
            i2cmtw_pkg::st_idle: begin
                q_d.ph = `I2CMTW_PH_DRIVE;
                if (go && cmd_in.op == i2cmtw_pkg::op_start) begin
                    q_d.st = i2cmtw_pkg::st_start;
                    q_d.sh = cmd_in.data;
                end
            end
            i2cmtw_pkg::st_hold_a, i2cmtw_pkg::st_hold_b: begin
                // scl stays low here: this is the wait state on the bus
                q_d.ph = `I2CMTW_PH_DRIVE;
                if (go) begin
                    case (cmd_in.op)
                        i2cmtw_pkg::op_start: begin
                            q_d.st = i2cmtw_pkg::st_start;
                            q_d.sh = cmd_in.data;
                        end
                        // from the after-bits wait the slave already pulls sda for its ack,
                        // so the ack is clocked first; the ack report then brings the stop
                        i2cmtw_pkg::op_stop: begin
                            q_d.st = (q_q.st == i2cmtw_pkg::st_hold_a) ?
                                     i2cmtw_pkg::st_ack : i2cmtw_pkg::st_stop;
                        end
                        i2cmtw_pkg::op_send: begin
                            q_d.st   = (q_q.st == i2cmtw_pkg::st_hold_a) ?
                                       i2cmtw_pkg::st_ack : i2cmtw_pkg::st_bits;
                            q_d.sh   = cmd_in.data;
                            q_d.bitn = 3'h0;
                        end
                        default: q_d.st = i2cmtw_pkg::st_ack;
                    endcase
                end
            end
            i2cmtw_pkg::st_start: begin
                // also serves as repeated start from a held, low scl
                case (q_q.ph)
                    `I2CMTW_PH_DRIVE: q_d.sda_oe = 1'b0;
                    `I2CMTW_PH_RISE:  q_d.scl_oe = 1'b0;
                    `I2CMTW_PH_MID:   q_d.sda_oe = 1'b1;
                    default: begin
                        q_d.scl_oe = 1'b1;
                        q_d.st     = i2cmtw_pkg::st_bits;
                        q_d.bitn   = 3'h0;
                    end
                endcase
            end
            i2cmtw_pkg::st_bits: begin
                case (q_q.ph)
                    `I2CMTW_PH_DRIVE: q_d.sda_oe = ~q_q.sh[7];
                    `I2CMTW_PH_RISE:  q_d.scl_oe = 1'b0;
                    `I2CMTW_PH_MID:   q_d.scl_oe = 1'b0;
                    default: begin
                        q_d.scl_oe = 1'b1;
                        if (!q_q.sda_oe && !q_q.d2) begin
                            // another master pulled sda low: let go of both lines
                            q_d.scl_oe = 1'b0;
                            q_d.sda_oe = 1'b0;
                            q_d.st     = i2cmtw_pkg::st_idle;
                            q_d.rpt    = '{i2cmtw_pkg::rpt_arb, 1'b0};
                            q_d.rtgl   = ~q_q.rtgl;
                        end else if (q_q.bitn == `I2CMTW_BIT_LAST) begin
                            q_d.st   = i2cmtw_pkg::st_hold_a;
                            q_d.rpt  = '{i2cmtw_pkg::rpt_bits, 1'b0};
                            q_d.rtgl = ~q_q.rtgl;
                        end else begin
                            q_d.bitn = q_q.bitn + 3'h1;
                            q_d.sh   = {q_q.sh[6:0], 1'b0};
                        end
                    end
                endcase
            end
            i2cmtw_pkg::st_ack: begin
                case (q_q.ph)
                    `I2CMTW_PH_DRIVE: q_d.sda_oe = 1'b0;
                    `I2CMTW_PH_RISE:  q_d.scl_oe = 1'b0;
                    `I2CMTW_PH_MID:   q_d.scl_oe = 1'b0;
                    default: begin
                        q_d.scl_oe = 1'b1;
                        q_d.st     = i2cmtw_pkg::st_hold_b;
                        q_d.rpt    = '{i2cmtw_pkg::rpt_ack, ~q_q.d2};
                        q_d.rtgl   = ~q_q.rtgl;
                    end
                endcase
            end
            i2cmtw_pkg::st_stop: begin
                case (q_q.ph)
                    `I2CMTW_PH_DRIVE: q_d.sda_oe = 1'b1;
                    `I2CMTW_PH_RISE:  q_d.scl_oe = 1'b0;
                    `I2CMTW_PH_MID:   q_d.sda_oe = 1'b0;
                    default: begin
                        q_d.st   = i2cmtw_pkg::st_idle;
                        q_d.rpt  = '{i2cmtw_pkg::rpt_done, 1'b0};
                        q_d.rtgl = ~q_q.rtgl;
                    end
                endcase
            end
            default: q_d.st = i2cmtw_pkg::st_idle;
        endcase
    end

    always_ff @(posedge link_clk_in or posedge rst_in) begin
        if (rst_in) begin
            q_q <= '0;
        end else begin
            q_q <= q_d;
        end
    end

endmodule : i2cmtw_link

// ===== tb/i2cmtw_monitor.sv
// i2cmtw checker: flag, wait and strobe relations at the top ports
`timescale 1ns/1ps

module i2cmtw_monitor (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic dma_mode_in,
    input wire logic reserved_detect_in,
    input wire logic tx_write_in,
    input wire logic master_select_write_in,
    input wire logic master_select_data_in,
    input wire logic repeat_start_request_in,
    input wire logic event_flag_clear_in,
    input wire logic bus_event_flag_out,
    input wire logic tx_bus_idle_flag_out,
    input wire logic tx_data_empty_out,
    input wire logic master_select_out,
    input wire logic bus_busy_status_out,
    input wire logic nack_out,
    input wire logic arb_lost_out,
    input wire logic scl_oe_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    chk_idle_dma: assert property ($rose(tx_bus_idle_flag_out) |-> dma_mode_in)
        else $error("idle flag raised outside dma mode");
    chk_event_dma: assert property ($rose(bus_event_flag_out) && dma_mode_in
        |-> nack_out || reserved_detect_in)
        else $error("event flag raised in dma mode without nack or reserved address");
    chk_event_hold: assert property (bus_event_flag_out && bus_busy_status_out &&
        !arb_lost_out |-> scl_oe_out)
        else $error("event wait without scl held low");
    chk_idle_hold: assert property (tx_bus_idle_flag_out && bus_busy_status_out
        |-> scl_oe_out)
        else $error("idle wait without scl held low");
    chk_stop_clear: assert property (master_select_write_in && !master_select_data_in &&
        bus_event_flag_out && nack_out |=> !bus_event_flag_out)
        else $error("stop during nack wait left the event flag set");
    chk_rs_clear: assert property (repeat_start_request_in && bus_event_flag_out &&
        master_select_out && !master_select_write_in |=> !bus_event_flag_out)
        else $error("repeated start left the event flag set");
    chk_dma_release: assert property (tx_write_in && tx_bus_idle_flag_out &&
        !master_select_write_in |=> !tx_bus_idle_flag_out)
        else $error("data write did not release the idle wait");
    chk_flag_clear: assert property (event_flag_clear_in && bus_event_flag_out &&
        !master_select_write_in |=> !bus_event_flag_out)
        else $error("flag clear did not clear the event flag");
    chk_tx_load: assert property (tx_write_in && !bus_busy_status_out
        |=> !tx_data_empty_out)
        else $error("transmit write left data empty set");
    chk_start_take: assert property (master_select_write_in && master_select_data_in &&
        !bus_busy_status_out |=> master_select_out && bus_busy_status_out)
        else $error("start request not taken");
endmodule : i2cmtw_monitor

bind i2cmtw_top i2cmtw_monitor u_mon (.*);

// ===== tb/i2cmtw_slave_model.sv
// i2cmtw slave model: acknowledges the address, optionally refuses data bytes
`timescale 1ns/1ps

module i2cmtw_slave_model (
    input  wire logic scl_in,
    input  wire logic sda_in,
    input  wire logic nack_data_in,
    output logic      ack_pull_out
);
    logic [3:0] rise_n;
    logic [3:0] byte_n;

    initial begin
        rise_n = 4'h0;
        byte_n = 4'h0;
        ack_pull_out = 1'b0;
    end

    // start or repeated start restarts the frame count
    always @(negedge sda_in) begin
        if (scl_in === 1'b1) begin
            rise_n = 4'h0;
            byte_n = 4'h0;
        end
    end

    always @(posedge scl_in) rise_n = rise_n + 4'h1;

    // only data bytes are refused, so the address wait is reachable in every case but fifo mode without a reserved address
    always @(negedge scl_in) begin
        if (rise_n == 4'h8) begin
            ack_pull_out = !(nack_data_in && byte_n != 4'h0);
        end else if (rise_n == 4'h9) begin
            ack_pull_out = 1'b0;
            rise_n = 4'h0;
            byte_n = byte_n + 4'h1;
        end
    end
endmodule : i2cmtw_slave_model

// ===== tb/test_i2cmtw_top.sv
// i2cmtw bench: row-driven master-transmit transfers against a slave model
`timescale 1ns/1ps

module test_i2cmtw_top;
    logic       sys_clk_in, link_clk_in, rst_in, dma_mode_in, fifo_mode_in;
    logic       wait_point_select_in, reserved_detect_in, tx_write_in, sda_in;
    logic [7:0] tx_data_in, receive_data_out;
    logic       master_select_write_in, master_select_data_in, repeat_start_request_in;
    logic       event_flag_clear_in, bus_event_flag_out, tx_bus_idle_flag_out;
    logic       tx_data_empty_out, master_select_out, bus_busy_status_out, nack_out;
    logic       arb_lost_out, scl_out, scl_oe_out, sda_out, sda_oe_out;
    logic       nack_data, ack_pull, rival;
    logic [7:0] rows [14];
    int         errors, comparisons;

    i2cmtw_top u_dut (.*);
    i2cmtw_slave_model u_slave (.scl_in(~scl_oe_out), .sda_in(sda_in),
        .nack_data_in(nack_data), .ack_pull_out(ack_pull));
    // open-drain wire with pull-up
    // rival stands for another master pulling sda low
    assign sda_in = ~(sda_oe_out | ack_pull | rival);

    initial begin
        sys_clk_in = 1'b0;
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end
    initial begin
        link_clk_in = 1'b0;
        #7;
        forever #24 link_clk_in = ~link_clk_in;
    end

    task automatic print_verdict;
        if (errors == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %0t %s", $time, what);
        end
    endtask : chk

    // k: 0 data write, 1 start, 2 stop, 3 flag clear, 4 repeated start
    task automatic pulse(input int k, input logic [7:0] d);
        @(negedge sys_clk_in);
        tx_data_in = d;
        master_select_data_in = (k == 1);
        tx_write_in = (k == 0);
        master_select_write_in = (k == 1 || k == 2);
        event_flag_clear_in = (k == 3);
        repeat_start_request_in = (k == 4);
        @(negedge sys_clk_in);
        {tx_write_in, master_select_write_in, event_flag_clear_in} = 3'h0;
        repeat_start_request_in = 1'b0;
    endtask : pulse

    // k: 0 waits for a flag, 1 waits for the bus to go idle
    task automatic wait_for(input int k);
        int n;
        for (n = 0; n < 4000; n++) begin
            @(negedge sys_clk_in);
            if (k == 0 && (bus_event_flag_out | tx_bus_idle_flag_out) === 1'b1) return;
            if (k == 1 && bus_busy_status_out === 1'b0) return;
        end
        errors++;
        $display("mismatch %0t wait expired", $time);
        print_verdict();
    endtask : wait_for

    // reset spans two link edges so the link side resets too
    task automatic do_reset;
        rst_in = 1'b1;
        repeat (2) @(posedge link_clk_in);
        @(negedge sys_clk_in);
        chk({1'b0, bus_event_flag_out, tx_bus_idle_flag_out, tx_data_empty_out,
            master_select_out, bus_busy_status_out, scl_oe_out, sda_oe_out}, 8'h10, "reset");
        rst_in = 1'b0;
        repeat (4) @(negedge sys_clk_in);
    endtask : do_reset

    // row: dma, fifo, select, nack, reserved, number of waits
    task automatic run_row(input logic [7:0] r);
        int   k;
        logic ev;
        @(negedge sys_clk_in);
        {dma_mode_in, fifo_mode_in, wait_point_select_in, nack_data, reserved_detect_in} = r[7:3];
        pulse(0, 8'ha4);
        pulse(1, 8'h00);
        if (fifo_mode_in) pulse(0, 8'h5b);
        for (k = 0; k < r[2:0]; k++) begin
            wait_for(0);
            ev = !r[7] || (r[4] && k == r[2:0] - 1) || (r[3] && k == 0);
            chk(bus_event_flag_out, ev, "event flag");
            chk(tx_bus_idle_flag_out, !ev, "idle flag");
            chk(scl_oe_out, 1'b1, "scl held low");
            chk(nack_out, r[4] && k == r[2:0] - 1, "nack flag");
            if (r[3] && k == 0) chk(receive_data_out, 8'ha4, "reserved address");
            if (k < r[2:0] - 1) begin
                pulse(0, 8'h3c);
                if (ev) pulse(3, 8'h00);
            end
        end
        pulse(2, 8'h00);
        if (r[4]) chk(bus_event_flag_out, 1'b0, "flag after stop");
        wait_for(1);
        chk(master_select_out, 1'b0, "master select after stop");
        pulse(3, 8'h00);
    endtask : run_row

    initial begin
        rst_in = 1'b1;
        {dma_mode_in, fifo_mode_in, wait_point_select_in, reserved_detect_in} = 4'h0;
        {tx_write_in, master_select_write_in, master_select_data_in} = 3'h0;
        {repeat_start_request_in, event_flag_clear_in, nack_data} = 3'h0;
        rival = 1'b0;
        tx_data_in = 8'h00;
        errors = 0;
        comparisons = 0;
        rows = '{8'h02, 8'h12, 8'h23, 8'h33, 8'h82, 8'hb3, 8'ha3,
                 8'h41, 8'h61, 8'hc1, 8'hd1, 8'he1, 8'h0a, 8'h8a};
        do_reset();
        foreach (rows[i]) begin
            run_row(rows[i]);
        end
        // repeated start from the wait after a refused byte
        @(negedge sys_clk_in);
        {dma_mode_in, fifo_mode_in, wait_point_select_in, nack_data, reserved_detect_in} = 5'h02;
        pulse(0, 8'ha4);
        pulse(1, 8'h00);
        wait_for(0);
        pulse(0, 8'h3c);
        pulse(3, 8'h00);
        wait_for(0);
        pulse(0, 8'ha6);
        pulse(4, 8'h00);
        chk(bus_event_flag_out, 1'b0, "flag after repeated start");
        chk(bus_busy_status_out, 1'b1, "busy across repeated start");
        wait_for(0);
        chk(receive_data_out, 8'ha6, "address after repeated start");
        pulse(2, 8'h00);
        wait_for(1);
        // another master holds sda low, so the first address bit is lost
        pulse(0, 8'ha4);
        pulse(1, 8'h00);
        rival = 1'b1;
        wait_for(0);
        chk({arb_lost_out, bus_event_flag_out, master_select_out, bus_busy_status_out},
            8'h0c, "arbitration lost");
        rival = 1'b0;
        wait_point_select_in = 1'b1;
        pulse(3, 8'h00);
        // reset in mid transfer
        pulse(0, 8'ha4);
        pulse(1, 8'h00);
        repeat (60) @(negedge sys_clk_in);
        do_reset();
        print_verdict();
    end
endmodule : test_i2cmtw_top
